// ### sfb_params.svh
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH
// register byte offsets
`define SFB_OFF_CTRL 12'h000
`define SFB_OFF_BAUD 12'h004
`define SFB_OFF_TXFP 12'h008
`define SFB_OFF_RXFP 12'h00c
`define SFB_OFF_STAT 12'h010
`define SFB_OFF_DATA 12'h014
// ctrl fields
`define SFB_C_TE 0
`define SFB_C_RE 1
`define SFB_C_MUTE 2
`define SFB_C_WAKE 3
`define SFB_C_LONG 4
`define SFB_C_PCE 5
`define SFB_C_PODD 6
`define SFB_C_TIE 7
`define SFB_C_TX_DONE_IRQ_EN 8
`define SFB_C_RIE 9
`define SFB_C_IDLE_IRQ_EN 10
`define SFB_C_PIE 11
// status fields
`define SFB_S_PE 0
`define SFB_S_FE 1
`define SFB_S_OR 3
`define SFB_S_IDLE 4
`define SFB_S_RXF 5
`define SFB_S_TC 6
`define SFB_S_TXE 7
`define SFB_CTRL_RST 12'h000
`define SFB_OVS 16
`define SFB_IDLE_SHORT 4'd10
`define SFB_IDLE_LONG 4'd11
`endif

// ### sfb_pkg.sv
package sfb_pkg;
   typedef enum logic [1:0] {
      SFB_IDLE = 2'b00,
      SFB_START = 2'b01,
      SFB_DATA = 2'b10,
      SFB_STOP = 2'b11
   } sfb_state_t;
endpackage : sfb_pkg

// ### sfb_top.sv
`timescale 1ns/1ps
`include "sfb_params.svh"
module sfb_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power and cpu
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic cpu_irq_mask,
   // serial line
   input wire logic rxd,
   output logic txd,
   // interrupt and wake
   output logic irq,
   output logic wait_wake
);
   logic [11:0] ctrl_q;
   logic [7:0] baud_q;
   logic [7:0] tx_fine_prescaler_q, rx_fine_prescaler_q;
   logic [8:0] tdr_q, rdr_q;
   logic txe_q, tc_q, rxf_q, idle_q, or_q, fe_q, pe_q;
   logic stat_read_q;
   logic wr, rd, run;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign run = ~halt_mode;
   // wait mode only gates wait_wake; the rest of the block ignores it
   logic len_long, parity_enable_ctl, mute;
   assign len_long = ctrl_q[`SFB_C_LONG];
   assign parity_enable_ctl = ctrl_q[`SFB_C_PCE];
   assign mute = ctrl_q[`SFB_C_MUTE];

   // baud ticks: x16 oversample tick per direction
   logic [5:0] coarse;
   always_comb begin
      unique case (baud_q[1:0])
         2'd0: coarse = 6'd1;
         2'd1: coarse = 6'd3;
         2'd2: coarse = 6'd4;
         2'd3: coarse = 6'd13;
      endcase
   end
   // widest product 255*13*128 needs 19 bits
   logic [19:0] tx_div, rx_div, tx_cnt_q, rx_cnt_q;
   logic [7:0] txf_eff, rxf_eff;
   assign txf_eff = (tx_fine_prescaler_q == 8'h00) ? 8'h01 : tx_fine_prescaler_q;
   assign rxf_eff = (rx_fine_prescaler_q == 8'h00) ? 8'h01 : rx_fine_prescaler_q;
   // fine * coarse * range per oversample tick; /16 in bit counters
   assign tx_div = 20'((txf_eff * coarse) << baud_q[4:2]);
   assign rx_div = 20'((rxf_eff * coarse) << baud_q[7:5]);
   logic tx_tick, rx_tick;
   // >= so a smaller divider written mid-count cannot leave the counter running away
   assign tx_tick = run && (tx_cnt_q >= tx_div - 20'd1);
   assign rx_tick = run && (rx_cnt_q >= rx_div - 20'd1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_q <= 20'h00000;
         rx_cnt_q <= 20'h00000;
      end else if (run) begin
         tx_cnt_q <= tx_tick ? 20'h00000 : tx_cnt_q + 20'd1;
         rx_cnt_q <= rx_tick ? 20'h00000 : rx_cnt_q + 20'd1;
      end
   end

   // transmitter
   sfb_pkg::sfb_state_t tst_q;
   logic [3:0] tsub_q, tbit_q;
   logic [9:0] tsh_q;
   logic tx_pend_q;
   logic [3:0] nbits;
   assign nbits = len_long ? 4'd9 : 4'd8;
   function automatic logic [8:0] tx_word(input logic [8:0] d, input logic lg,
                                          input logic pc, input logic od);
      logic p;
      logic [8:0] w;
      p = lg ? ^d[7:0] : ^d[6:0];
      p = p ^ od;
      w = d;
      if (pc) begin
         if (lg) w[8] = p;
         else w[7] = p;
      end
      if (!lg) w[8] = 1'b0;
      return w;
   endfunction : tx_word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tst_q <= sfb_pkg::SFB_IDLE;
         tsub_q <= 4'h0;
         tbit_q <= 4'h0;
         tsh_q <= 10'h000;
         txd <= 1'b1;
      end else if (tx_tick) begin
         tsub_q <= tsub_q + 4'd1;
         unique case (tst_q)
            sfb_pkg::SFB_IDLE: begin
               txd <= 1'b1;
               if (tx_pend_q && ctrl_q[`SFB_C_TE]) begin
                  // parity settings sampled at load time
                  tsh_q <= {1'b0, tx_word(tdr_q, len_long, parity_enable_ctl, ctrl_q[`SFB_C_PODD])};
                  tst_q <= sfb_pkg::SFB_START;
                  tsub_q <= 4'h0;
                  txd <= 1'b0;
               end
            end
            sfb_pkg::SFB_START: if (tsub_q == 4'hf) begin
               tst_q <= sfb_pkg::SFB_DATA;
               tbit_q <= 4'h0;
               txd <= tsh_q[0];
               tsh_q <= tsh_q >> 1;
            end
            sfb_pkg::SFB_DATA: if (tsub_q == 4'hf) begin
               if (tbit_q == nbits - 4'd1) begin
                  tst_q <= sfb_pkg::SFB_STOP;
                  txd <= 1'b1;
               end else begin
                  tbit_q <= tbit_q + 4'd1;
                  txd <= tsh_q[0];
                  tsh_q <= tsh_q >> 1;
               end
            end
            sfb_pkg::SFB_STOP: if (tsub_q == 4'hf) tst_q <= sfb_pkg::SFB_IDLE;
         endcase
      end
   end
   logic tx_load, tx_end;
   assign tx_load = tx_tick && tst_q == sfb_pkg::SFB_IDLE && tx_pend_q && ctrl_q[`SFB_C_TE];
   assign tx_end = tx_tick && tst_q == sfb_pkg::SFB_STOP && tsub_q == 4'hf;

   // receiver
   sfb_pkg::sfb_state_t rst_q;
   logic [3:0] rsub_q, rbit_q, idle_bits_q;
   logic [8:0] rsh_q;
   logic idle_armed_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_q <= sfb_pkg::SFB_IDLE;
         rsub_q <= 4'h0;
         rbit_q <= 4'h0;
         rsh_q <= 9'h000;
      end else if (rx_tick && ctrl_q[`SFB_C_RE]) begin
         rsub_q <= rsub_q + 4'd1;
         unique case (rst_q)
            sfb_pkg::SFB_IDLE: if (!rxd) begin
               rst_q <= sfb_pkg::SFB_START;
               rsub_q <= 4'h0;
            end
            sfb_pkg::SFB_START: if (rsub_q == 4'h7) begin
               rst_q <= rxd ? sfb_pkg::SFB_IDLE : sfb_pkg::SFB_DATA;
               rsub_q <= 4'h0;
               rbit_q <= 4'h0;
            end
            sfb_pkg::SFB_DATA: if (rsub_q == 4'hf) begin
               rsh_q <= len_long ? {rxd, rsh_q[8:1]} : {1'b0, rxd, rsh_q[7:1]};
               if (rbit_q == nbits - 4'd1) rst_q <= sfb_pkg::SFB_STOP;
               else rbit_q <= rbit_q + 4'd1;
            end
            sfb_pkg::SFB_STOP: if (rsub_q == 4'hf) rst_q <= sfb_pkg::SFB_IDLE;
         endcase
      end
   end
   logic rx_done, mark, perr, line_idle;
   assign rx_done = rx_tick && ctrl_q[`SFB_C_RE] && rst_q == sfb_pkg::SFB_STOP
                    && rsub_q == 4'hf;
   // with parity on, the top received bit is parity, so the mark sits one below
   assign mark = parity_enable_ctl ? (len_long ? rsh_q[7] : rsh_q[6]) : (len_long ? rsh_q[8] : rsh_q[7]);
   assign perr = parity_enable_ctl && (ctrl_q[`SFB_C_PODD] ^ (len_long ? ^rsh_q[8:0] : ^rsh_q[7:0]));
   // idle: high for 10/11 bit times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_bits_q <= 4'h0;
         idle_armed_q <= 1'b0;
      end else if (rx_tick && ctrl_q[`SFB_C_RE]) begin
         if (!rxd) begin
            idle_bits_q <= 4'h0;
            idle_armed_q <= 1'b1;
         end else if (rst_q == sfb_pkg::SFB_IDLE && rsub_q == 4'hf && idle_armed_q) begin
            if (line_idle) begin
               idle_bits_q <= 4'h0;
               idle_armed_q <= 1'b0;
            end else begin
               idle_bits_q <= idle_bits_q + 4'd1;
            end
         end
      end
   end
   // counts from the middle of the stop bit; sender gaps must stay shorter
   assign line_idle = rx_tick && ctrl_q[`SFB_C_RE] && rxd && idle_armed_q
                      && rst_q == sfb_pkg::SFB_IDLE && rsub_q == 4'hf
                      && idle_bits_q == (len_long ? `SFB_IDLE_LONG : `SFB_IDLE_SHORT) - 4'd1;
   logic wake_idle, wake_mark;
   assign wake_idle = mute && !ctrl_q[`SFB_C_WAKE] && line_idle;
   assign wake_mark = mute && ctrl_q[`SFB_C_WAKE] && rx_done && mark;
   logic rx_take;
   assign rx_take = rx_done && (!mute || wake_mark);

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SFB_CTRL_RST;
         baud_q <= 8'h00;
         tx_fine_prescaler_q <= 8'h00;
         rx_fine_prescaler_q <= 8'h00;
      end else if (run) begin
         if (wr && paddr == `SFB_OFF_CTRL) ctrl_q <= pwdata[11:0];
         else if (wake_idle || wake_mark) ctrl_q[`SFB_C_MUTE] <= 1'b0;
         if (wr && paddr == `SFB_OFF_BAUD) baud_q <= pwdata[7:0];
         if (wr && paddr == `SFB_OFF_TXFP) tx_fine_prescaler_q <= pwdata[7:0];
         if (wr && paddr == `SFB_OFF_RXFP) rx_fine_prescaler_q <= pwdata[7:0];
      end
   end
   logic data_wr, data_rd, stat_rd;
   assign data_wr = run && wr && paddr == `SFB_OFF_DATA;
   assign data_rd = run && rd && paddr == `SFB_OFF_DATA;
   assign stat_rd = run && rd && paddr == `SFB_OFF_STAT;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_read_q <= 1'b0;
         tdr_q <= 9'h000;
         tx_pend_q <= 1'b0;
         txe_q <= 1'b1;
         tc_q <= 1'b1;
      end else if (run) begin
         if (stat_rd) stat_read_q <= 1'b1;
         else if (data_wr || data_rd) stat_read_q <= 1'b0;
         if (data_wr) begin
            tdr_q <= pwdata[8:0];
            tx_pend_q <= 1'b1;
         end else if (tx_load) begin
            tx_pend_q <= 1'b0;
         end
         // set wins over the clear sequence
         if (tx_load) txe_q <= 1'b1;
         else if (data_wr && stat_read_q) txe_q <= 1'b0;
         if (tx_end) tc_q <= 1'b1;
         else if (data_wr && stat_read_q) tc_q <= 1'b0;
      end
   end
   logic rx_clr;
   assign rx_clr = data_rd && stat_read_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdr_q <= 9'h000;
         rxf_q <= 1'b0;
         or_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
         idle_q <= 1'b0;
      end else if (run) begin
         if (rx_take && !rxf_q) begin
            rdr_q <= rsh_q;
            rxf_q <= 1'b1;
            fe_q <= !rxd;
            pe_q <= perr;
         end else if (rx_take) begin
            or_q <= 1'b1;
         end else if (rx_clr) begin
            rxf_q <= 1'b0;
            or_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
         end
         if (line_idle && !mute) idle_q <= 1'b1;
         else if (rx_clr) idle_q <= 1'b0;
      end
   end
   logic [7:0] stat;
   assign stat = {txe_q, tc_q, rxf_q, idle_q, or_q, 1'b0, fe_q, pe_q};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `SFB_OFF_CTRL: prdata <= {20'h00000, ctrl_q};
            `SFB_OFF_BAUD: prdata <= {24'h000000, baud_q};
            `SFB_OFF_TXFP: prdata <= {24'h000000, tx_fine_prescaler_q};
            `SFB_OFF_RXFP: prdata <= {24'h000000, rx_fine_prescaler_q};
            `SFB_OFF_STAT: prdata <= {24'h000000, stat};
            `SFB_OFF_DATA: prdata <= {23'h000000, rdr_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   // one shared line; halt prevents exit
   logic any_ev, rx_ev;
   // receive sources stay silent while muted, even when flagged before muting
   assign rx_ev = ((rxf_q | or_q) & ctrl_q[`SFB_C_RIE]) | (idle_q & ctrl_q[`SFB_C_IDLE_IRQ_EN])
                | (pe_q & ctrl_q[`SFB_C_PIE]);
   assign any_ev = (txe_q & ctrl_q[`SFB_C_TIE]) | (tc_q & ctrl_q[`SFB_C_TX_DONE_IRQ_EN])
                 | (rx_ev & ~mute);
   assign irq = any_ev & ~cpu_irq_mask & run;
   assign wait_wake = irq & wait_mode;
endmodule : sfb_top

// ### sfb_top_asserts.sv
`timescale 1ns/1ps
module sfb_top_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // power and cpu
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic cpu_irq_mask,
   // line and interrupt
   input wire logic txd,
   input wire logic irq,
   input wire logic wait_wake
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // the shortest bit is 16 clocks, so no level on txd may end before 9
   sequence s_fall;
      $fell(txd);
   endsequence
   sequence s_low8;
      !txd [*8];
   endsequence
   sequence s_rise;
      $rose(txd);
   endsequence
   sequence s_high8;
      txd [*8];
   endsequence
   a_reset_txd_high: assert property ($rose(presetn) |-> txd)
      else $error("txd not idle high after reset");
   a_start_bit_len: assert property (s_fall |=> s_low8)
      else $error("low level on txd too short");
   a_high_bit_len: assert property (s_rise |=> s_high8)
      else $error("high level on txd too short");
   a_halt_txd_frozen: assert property ($past(halt_mode) |-> $stable(txd))
      else $error("txd moved during halt");
   a_halt_no_irq: assert property (halt_mode |-> !irq)
      else $error("irq raised during halt");
   a_halt_no_wake: assert property (halt_mode |-> !wait_wake)
      else $error("wake raised during halt");
   a_mask_no_irq: assert property (cpu_irq_mask |-> !irq)
      else $error("irq raised while masked");
   a_wait_wake_irq: assert property (wait_wake == (irq && wait_mode))
      else $error("wake does not follow irq in wait");
endmodule : sfb_top_asserts

bind sfb_top sfb_top_asserts sfb_top_asserts_inst (.pclk(pclk), .presetn(presetn),
   .halt_mode(halt_mode), .wait_mode(wait_mode), .cpu_irq_mask(cpu_irq_mask),
   .txd(txd), .irq(irq), .wait_wake(wait_wake));

// ### sfb_node.sv
`timescale 1ns/1ps
module sfb_node (
   // clock
   input wire logic pclk,
   // line
   input wire logic txd,
   output logic rxd
);
   // bit time in clocks, the bench keeps it at 16 times the programmed divider
   int bt = 32;
   initial rxd = 1'b1;
   // frames go back to back, so no gap can pass for an idle line
   task automatic send(input logic [8:0] v, input int nb);
      rxd <= 1'b0;
      repeat (bt) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         rxd <= v[i];
         repeat (bt) @(posedge pclk);
      end
      rxd <= 1'b1;
      repeat (bt) @(posedge pclk);
   endtask : send
   task automatic grab(input int nb, output logic [8:0] v, output bit ok);
      int n;
      n = 0;
      v = '0;
      while (txd !== 1'b0 && n < 4000) begin
         @(posedge pclk);
         n++;
      end
      repeat (bt / 2) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         repeat (bt) @(posedge pclk);
         v[i] = txd;
      end
      repeat (bt) @(posedge pclk);
      ok = (n < 4000) && (txd === 1'b1);
   endtask : grab
endmodule : sfb_node

// ### tb_sfb_top.sv
`timescale 1ns/1ps
`include "sfb_params.svh"
module tb_sfb_top;
   logic pclk, presetn, psel, penable, pwrite, halt_mode, wait_mode, cpu_irq_mask;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, rxd, txd, irq, wait_wake;
   logic [8:0] got;
   bit ok;
   int num_errors = 0;
   int n_compared = 0;
   logic [8:0] t_ctl [5] = '{9'h021, 9'h061, 9'h071, 9'h011, 9'h001};
   logic [8:0] t_dat [5] = '{9'h0b5, 9'h035, 9'h035, 9'h1a5, 9'h0a5};
   logic [8:0] t_exp [5] = '{9'h035, 9'h0b5, 9'h135, 9'h1a5, 9'h0a5};
   int t_fp [5] = '{2, 2, 2, 0, 1};
   int t_bd [5] = '{0, 0, 0, 0, 5};
   int t_bt [5] = '{32, 32, 32, 16, 96};
   int t_nb [5] = '{8, 8, 9, 9, 8};

   sfb_top sfb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_mode(halt_mode), .wait_mode(wait_mode),
      .cpu_irq_mask(cpu_irq_mask), .rxd(rxd), .txd(txd), .irq(irq), .wait_wake(wait_wake));
   sfb_node sfb_node_inst (.pclk(pclk), .txd(txd), .rxd(rxd));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic test_done;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // a hung wait counts against the run and ends it
   task automatic cut;
      num_errors++;
      test_done();
   endtask : cut
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) cut();
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask : rdc

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {halt_mode, wait_mode, cpu_irq_mask, presetn} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(irq, 1'b0);
      for (int i = 0; i < 5; i++) begin
         sfb_node_inst.bt = t_bt[i];
         wr(`SFB_OFF_CTRL, 32'h0);
         wr(`SFB_OFF_BAUD, t_bd[i]);
         wr(`SFB_OFF_TXFP, t_fp[i]);
         wr(`SFB_OFF_CTRL, t_ctl[i]);
         apb(1'b0, `SFB_OFF_STAT, 32'h0);
         wr(`SFB_OFF_DATA, t_dat[i]);
         sfb_node_inst.grab(t_nb[i], got, ok);
         if (!ok) cut();
         chk(got, t_exp[i]);
         repeat (t_bt[i]) @(posedge pclk);
      end
      wr(`SFB_OFF_CTRL, 32'h100);
      chk(irq, 1'b1);
      $display("tx formats done");
      sfb_node_inst.bt = 32;
      wr(`SFB_OFF_CTRL, 32'h0);
      wr(`SFB_OFF_BAUD, 32'h0);
      wr(`SFB_OFF_RXFP, 32'h2);
      wr(`SFB_OFF_CTRL, 32'h822);
      sfb_node_inst.send(9'h0b5, 8);
      rdc(`SFB_OFF_STAT, 32'h21, 32'h21);
      chk(irq, 1'b1);
      cpu_irq_mask <= 1'b1;
      @(posedge pclk);
      chk(irq, 1'b0);
      cpu_irq_mask <= 1'b0;
      wait_mode <= 1'b1;
      @(posedge pclk);
      chk(wait_wake, 1'b1);
      wait_mode <= 1'b0;
      halt_mode <= 1'b1;
      @(posedge pclk);
      chk(irq, 1'b0);
      wr(`SFB_OFF_CTRL, 32'h0);
      rdc(`SFB_OFF_CTRL, 32'hfff, 32'h822);
      halt_mode <= 1'b0;
      apb(1'b0, `SFB_OFF_STAT, 32'h0);
      apb(1'b0, `SFB_OFF_DATA, 32'h0);
      sfb_node_inst.send(9'h035, 8);
      rdc(`SFB_OFF_STAT, 32'h21, 32'h20);
      apb(1'b0, `SFB_OFF_DATA, 32'h0);
      $display("rx parity done");
      wr(`SFB_OFF_CTRL, 32'h006);
      sfb_node_inst.send(9'h012, 8);
      rdc(`SFB_OFF_STAT, 32'h20, 32'h0);
      repeat (12 * 32) @(posedge pclk);
      rdc(`SFB_OFF_CTRL, 32'h4, 32'h0);
      rdc(`SFB_OFF_STAT, 32'h10, 32'h0);
      wr(`SFB_OFF_CTRL, 32'h00e);
      sfb_node_inst.send(9'h012, 8);
      rdc(`SFB_OFF_CTRL, 32'h4, 32'h4);
      sfb_node_inst.send(9'h092, 8);
      rdc(`SFB_OFF_CTRL, 32'h4, 32'h0);
      rdc(`SFB_OFF_STAT, 32'h20, 32'h20);
      rdc(`SFB_OFF_DATA, 32'hff, 32'h92);
      wr(`SFB_OFF_CTRL, 32'h03e);
      sfb_node_inst.send(9'h101, 9);
      rdc(`SFB_OFF_CTRL, 32'h4, 32'h4);
      sfb_node_inst.send(9'h180, 9);
      rdc(`SFB_OFF_CTRL, 32'h4, 32'h0);
      $display("rx mute and wake done");
      test_done();
   end
endmodule : tb_sfb_top
